/* File: inc/cmd_decode_pkg.sv */
/*
 Package for the direct command decoder: command codes, gain and history constants, strobe and state types.
 Assumes a 40 MHz system clock and a byte-wide command strobe from the host port.
*/
package cmd_decode_pkg;
    localparam logic [7:0] CMD_MASK_RX = 8'hd0;
    localparam logic [7:0] CMD_UNMASK_RX = 8'hd1;
    localparam logic [7:0] CMD_AM_TOGGLE = 8'hd2;
    localparam logic [7:0] CMD_MEAS_AMP = 8'hd3;
    localparam logic [7:0] CMD_RX_GAIN_RST = 8'hd5;
    localparam logic [7:0] CMD_ADJ_REG = 8'hd6;
    localparam logic [7:0] CMD_CAL_DRV = 8'hd8;
    localparam logic [7:0] CMD_MEAS_PHASE = 8'hd9;
    localparam logic [7:0] CMD_CLR_RSSI = 8'hda;
    localparam logic [7:0] CMD_CLR_FIFO = 8'hdb;
    localparam logic [7:0] CMD_TRANSPARENT = 8'hdc;
    localparam logic [7:0] CMD_MASK_TIMER = 8'he2;
    localparam logic [3:0] RX_GAIN_RESET = 4'h0;
    localparam int unsigned GAIN_REG_INDEX = 4;
    localparam int unsigned HIST_DEPTH = 8;
    localparam logic [2:0] HIST_PTR_ONE = 3'h1;

    typedef struct packed {
        logic rx_stop;
        logic rx_start;
        logic am_toggle;
        logic meas_amp;
        logic gain_reload;
        logic adj_reg;
        logic cal_drv;
        logic meas_phase;
        logic rssi_clear;
        logic fifo_clear;
        logic transparent;
        logic mask_timer;
    } unit_strobe_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEAS_WAIT = 2'b01,
        ST_MEAS_DONE = 2'b11
    } meas_state_t;
endpackage

/* File: rtl/cmd_hist_mem.sv */
/*
 Small history memory of accepted command codes, registered read port.
 Assumes one synchronous clock domain shared with the decoder.
*/
`timescale 1ns/1ps
`default_nettype none
module cmd_hist_mem (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:cmd_decode_pkg::HIST_DEPTH-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // cmd_hist_mem
`default_nettype wire

/* File: rtl/nfc_direct_command_decoder.sv */
/*
 Direct command decoder: takes one command byte per strobe, checks the mode
 condition, and pulses one strobe to the controlled unit.
 Assumes cmd_valid is a one-cycle pulse from the host port logic on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module nfc_direct_command_decoder (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic dev_en,
    input wire logic tx_en,
    input wire logic meas_done,
    input wire logic [3:0] rx_cfg4_gain,
    input wire logic [2:0] hist_rd_addr,
    output logic [7:0] hist_rd_data,
    output cmd_decode_pkg::unit_strobe_t strobe_reg,
    output logic rx_masked_reg,
    output logic am_state_reg,
    output logic [3:0] rx_gain_reg,
    output logic transparent_reg,
    output logic meas_irq_reg,
    output logic cmd_ignored_reg,
    output logic chain_ok_reg
);
    ////////////////////////////////////////////////////////////////////////////
    // Decode
    cmd_decode_pkg::meas_state_t meas_state_reg;
    cmd_decode_pkg::meas_state_t meas_state_next;

    wire is_mask = cmd_code == cmd_decode_pkg::CMD_MASK_RX;
    wire is_unmask = cmd_code == cmd_decode_pkg::CMD_UNMASK_RX;
    wire is_am = cmd_code == cmd_decode_pkg::CMD_AM_TOGGLE;
    wire is_amp = cmd_code == cmd_decode_pkg::CMD_MEAS_AMP;
    wire is_gain = cmd_code == cmd_decode_pkg::CMD_RX_GAIN_RST;
    wire is_adj = cmd_code == cmd_decode_pkg::CMD_ADJ_REG;
    wire is_cal = cmd_code == cmd_decode_pkg::CMD_CAL_DRV;
    wire is_phase = cmd_code == cmd_decode_pkg::CMD_MEAS_PHASE;
    wire is_rssi = cmd_code == cmd_decode_pkg::CMD_CLR_RSSI;
    wire is_fifo = cmd_code == cmd_decode_pkg::CMD_CLR_FIFO;
    wire is_transp = cmd_code == cmd_decode_pkg::CMD_TRANSPARENT;
    wire is_mtimer = cmd_code == cmd_decode_pkg::CMD_MASK_TIMER;
    wire known = is_mask | is_unmask | is_am | is_amp | is_gain | is_adj | is_cal
        | is_phase | is_rssi | is_fifo | is_transp | is_mtimer;
    wire need_en = is_am | is_gain | is_adj | is_cal | is_rssi | is_fifo | is_transp | is_mtimer;
    wire mode_ok = (!need_en || dev_en) && (!is_am || tx_en);
    wire busy = meas_state_reg != cmd_decode_pkg::ST_IDLE;
    wire take_cmd = cmd_valid && known && mode_ok && !(is_amp && busy);
    wire chainable = is_mask | is_unmask | is_am | is_fifo | is_mtimer;

    ////////////////////////////////////////////////////////////////////////////
    // Strobes and state
    cmd_decode_pkg::unit_strobe_t strobe_next;
    logic [2:0] hist_ptr_reg;

    assign strobe_next.rx_stop = take_cmd && is_mask;
    assign strobe_next.rx_start = take_cmd && is_unmask;
    assign strobe_next.am_toggle = take_cmd && is_am;
    assign strobe_next.meas_amp = take_cmd && is_amp;
    assign strobe_next.gain_reload = take_cmd && is_gain;
    assign strobe_next.adj_reg = take_cmd && is_adj;
    assign strobe_next.cal_drv = take_cmd && is_cal;
    assign strobe_next.meas_phase = take_cmd && is_phase;
    assign strobe_next.rssi_clear = take_cmd && is_rssi;
    assign strobe_next.fifo_clear = take_cmd && is_fifo;
    assign strobe_next.transparent = take_cmd && is_transp;
    assign strobe_next.mask_timer = take_cmd && is_mtimer;

    always_comb begin
        meas_state_next = meas_state_reg;
        case (meas_state_reg)
            cmd_decode_pkg::ST_IDLE: begin
                if (strobe_next.meas_amp) begin
                    meas_state_next = cmd_decode_pkg::ST_MEAS_WAIT;
                end
            end
            cmd_decode_pkg::ST_MEAS_WAIT: begin
                if (meas_done) begin
                    meas_state_next = cmd_decode_pkg::ST_MEAS_DONE;
                end
            end
            cmd_decode_pkg::ST_MEAS_DONE: begin
                meas_state_next = cmd_decode_pkg::ST_IDLE;
            end
            default: begin
                meas_state_next = cmd_decode_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meas_state_reg <= cmd_decode_pkg::ST_IDLE;
            strobe_reg <= '0;
            meas_irq_reg <= 1'b0;
            cmd_ignored_reg <= 1'b0;
            chain_ok_reg <= 1'b0;
        end else begin
            meas_state_reg <= meas_state_next;
            strobe_reg <= strobe_next;
            meas_irq_reg <= meas_state_reg == cmd_decode_pkg::ST_MEAS_WAIT && meas_done;
            cmd_ignored_reg <= cmd_valid && !take_cmd;
            chain_ok_reg <= take_cmd && chainable;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_masked_reg <= 1'b0;
            am_state_reg <= 1'b0;
            rx_gain_reg <= cmd_decode_pkg::RX_GAIN_RESET;
            transparent_reg <= 1'b0;
            hist_ptr_reg <= '0;
        end else begin
            if (strobe_next.rx_stop) begin
                rx_masked_reg <= 1'b1;
            end else if (strobe_next.rx_start) begin
                rx_masked_reg <= 1'b0;
            end
            if (strobe_next.am_toggle) begin
                am_state_reg <= !am_state_reg;
            end
            if (strobe_next.gain_reload) begin
                rx_gain_reg <= rx_cfg4_gain;
            end
            if (strobe_next.transparent) begin
                transparent_reg <= 1'b1;
            end
            if (take_cmd) begin
                hist_ptr_reg <= hist_ptr_reg + cmd_decode_pkg::HIST_PTR_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command history
    cmd_hist_mem u_hist (
        .sys_clk(sys_clk),
        .wr_en(take_cmd),
        .wr_addr(hist_ptr_reg),
        .wr_data(cmd_code),
        .rd_addr(hist_rd_addr),
        .rd_data(hist_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_mask_stops_rx: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_mask |=> strobe_reg.rx_stop && rx_masked_reg)
        else $error("mask command did not stop receivers");
    chk_unmask_starts_rx: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_unmask |=> strobe_reg.rx_start && !rx_masked_reg)
        else $error("unmask command did not restart receivers");
    chk_am_toggle_cond: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_am && dev_en && tx_en |=> am_state_reg != $past(am_state_reg))
        else $error("AM state not toggled");
    chk_amp_irq_done: assert property (@(posedge sys_clk) disable iff (!rst_b)
        meas_state_reg == cmd_decode_pkg::ST_MEAS_WAIT && meas_done |=> meas_irq_reg ##1 !meas_irq_reg)
        else $error("measurement interrupt wrong");
    chk_amp_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strobe_reg.meas_amp |-> meas_state_reg == cmd_decode_pkg::ST_MEAS_WAIT && !chain_ok_reg)
        else $error("amplitude measurement not started");
    chk_gain_reload: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strobe_reg.gain_reload |-> rx_gain_reg == $past(rx_cfg4_gain))
        else $error("gain not reloaded");
    chk_fifo_needs_en: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strobe_reg.fifo_clear |-> $past(dev_en) && chain_ok_reg)
        else $error("fifo clear without enable");
    chk_ignored_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_ignored_reg |-> strobe_reg == '0)
        else $error("ignored command had side effect");
    chk_transp_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strobe_reg.transparent |-> transparent_reg [*2])
        else $error("transparent mode not entered");
    chk_timer_en: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_mtimer && !dev_en |=> !strobe_reg.mask_timer && cmd_ignored_reg)
        else $error("timer started while disabled");

    ////////////////////////////////////////////////////////////////////////////
    // Accepted command checks
    chk_adj_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_adj && dev_en |=> strobe_reg.adj_reg)
        else $error("regulator adjust not started");
    chk_cal_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_cal && dev_en |=> strobe_reg.cal_drv)
        else $error("driver calibration not started");
    chk_phase_any_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_phase |=> strobe_reg.meas_phase && !cmd_ignored_reg)
        else $error("phase measurement not started");
    chk_rssi_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_rssi && dev_en |=> strobe_reg.rssi_clear)
        else $error("signal strength clear not started");
    chk_fifo_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_fifo && dev_en |=> strobe_reg.fifo_clear && chain_ok_reg)
        else $error("fifo clear not started");
    chk_timer_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_mtimer && dev_en |=> strobe_reg.mask_timer && chain_ok_reg)
        else $error("mask timer not started");
    chk_transp_enter: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_transp && dev_en |=> strobe_reg.transparent && transparent_reg && !chain_ok_reg)
        else $error("transparent mode entry wrong");
    chk_gain_not_chain: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strobe_reg.gain_reload |-> !chain_ok_reg)
        else $error("gain reload marked chainable");
    chk_amp_accept: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_amp && !busy |=> strobe_reg.meas_amp)
        else $error("amplitude measurement not accepted");
    chk_am_chain: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strobe_reg.am_toggle |-> chain_ok_reg)
        else $error("AM toggle not chainable");
    chk_mask_any_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_mask |=> chain_ok_reg && !cmd_ignored_reg)
        else $error("mask command refused");
    chk_unmask_any_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_unmask |=> chain_ok_reg && !cmd_ignored_reg)
        else $error("unmask command refused");

    ////////////////////////////////////////////////////////////////////////////
    // Refusal checks
    chk_adj_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_adj && !dev_en |=> !strobe_reg.adj_reg && cmd_ignored_reg)
        else $error("regulator adjust while disabled");
    chk_cal_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_cal && !dev_en |=> !strobe_reg.cal_drv && cmd_ignored_reg)
        else $error("calibration while disabled");
    chk_rssi_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_rssi && !dev_en |=> !strobe_reg.rssi_clear && cmd_ignored_reg)
        else $error("signal strength clear while disabled");
    chk_fifo_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_fifo && !dev_en |=> !strobe_reg.fifo_clear && cmd_ignored_reg)
        else $error("fifo clear while disabled");
    chk_gain_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_gain && !dev_en |=> $stable(rx_gain_reg) && cmd_ignored_reg)
        else $error("gain changed while disabled");
    chk_transp_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_transp && !dev_en |=> $stable(transparent_reg) && cmd_ignored_reg)
        else $error("transparent mode while disabled");
    chk_am_needs_tx: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_am && !tx_en |=> $stable(am_state_reg) && cmd_ignored_reg)
        else $error("AM toggled with transmitter off");
    chk_amp_busy_refuse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && is_amp && busy |=> !strobe_reg.meas_amp && cmd_ignored_reg)
        else $error("measurement restarted while busy");
    chk_unknown_ignored: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && !known |=> cmd_ignored_reg && strobe_reg == '0)
        else $error("unknown code not ignored");
    chk_strobe_onehot: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $onehot0(strobe_reg))
        else $error("more than one unit strobed");
    chk_ignored_no_chain: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_ignored_reg |-> !chain_ok_reg)
        else $error("ignored command marked chainable");

    ////////////////////////////////////////////////////////////////////////////
    // State hold checks
    chk_am_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !strobe_reg.am_toggle |-> $stable(am_state_reg))
        else $error("AM state changed without command");
    chk_gain_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !strobe_reg.gain_reload |-> $stable(rx_gain_reg))
        else $error("gain changed without command");
    chk_mask_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !strobe_reg.rx_stop && !strobe_reg.rx_start |-> $stable(rx_masked_reg))
        else $error("receiver mask changed without command");
    chk_transp_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !strobe_reg.transparent |-> $stable(transparent_reg))
        else $error("transparent mode changed without command");
    chk_irq_only_done: assert property (@(posedge sys_clk) disable iff (!rst_b)
        meas_irq_reg |-> meas_state_reg == cmd_decode_pkg::ST_MEAS_DONE)
        else $error("interrupt outside measurement end");
    chk_irq_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        meas_irq_reg |=> !meas_irq_reg)
        else $error("interrupt longer than one cycle");
    chk_done_to_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        meas_state_reg == cmd_decode_pkg::ST_MEAS_DONE |=> meas_state_reg == cmd_decode_pkg::ST_IDLE)
        else $error("measurement did not return to idle");
    chk_hist_ptr_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
        take_cmd |=> hist_ptr_reg == $past(hist_ptr_reg) + cmd_decode_pkg::HIST_PTR_ONE)
        else $error("history pointer did not advance");
    chk_hist_ptr_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !take_cmd |=> $stable(hist_ptr_reg))
        else $error("history pointer moved on refused command");
    chk_chain_only_taken: assert property (@(posedge sys_clk) disable iff (!rst_b)
        chain_ok_reg |-> strobe_reg != '0)
        else $error("chain flag without accepted command");
    cov_amp_cycle: cover property (@(posedge sys_clk) disable iff (!rst_b)
        strobe_reg.meas_amp ##[1:20] meas_irq_reg);
    cov_chain_pair: cover property (@(posedge sys_clk) disable iff (!rst_b)
        chain_ok_reg ##1 chain_ok_reg);
    cov_ignored: cover property (@(posedge sys_clk) disable iff (!rst_b) cmd_ignored_reg);
    cov_am_refused: cover property (@(posedge sys_clk) disable iff (!rst_b) cmd_valid && is_am && !tx_en);
    cov_busy_refuse: cover property (@(posedge sys_clk) disable iff (!rst_b) cmd_valid && is_amp && busy);
endmodule // nfc_direct_command_decoder
`default_nettype wire

/* File: bench/host_cmd_model.sv */
/*
 Host-side model: issues single command bytes to the decoder.
 Assumes the decoder samples cmd_valid on the rising edge of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
    input wire logic sys_clk,
    output logic cmd_valid,
    output logic [7:0] cmd_code
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
    end

    // One code byte per strobe, changed 2 ns after the edge
    task automatic issue(input logic [7:0] code);
        @(posedge sys_clk);
        #2;
        cmd_valid = 1'b1;
        cmd_code = code;
        @(posedge sys_clk);
        #2;
        cmd_valid = 1'b0;
        cmd_code = ~code;
    endtask
endmodule // host_cmd_model
`default_nettype wire

/* File: bench/test_nfc_direct_command_decoder.sv */
/*
 Self-checking bench for the direct command decoder.
 Assumes the host model drives commands and the bench drives mode levels.
*/
`timescale 1ns/1ps
`default_nettype none
module test_nfc_direct_command_decoder;
    logic sys_clk, rst_b, cmd_valid, dev_en, tx_en, meas_done;
    logic [7:0] cmd_code, hist_rd_data;
    logic [2:0] hist_rd_addr;
    logic [3:0] rx_cfg4_gain, rx_gain_reg;
    cmd_decode_pkg::unit_strobe_t strobe_reg;
    logic rx_masked_reg, am_state_reg, transparent_reg, meas_irq_reg, cmd_ignored_reg, chain_ok_reg;
    int mismatches, n_tests;
    logic [7:0] codes [12] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd5, 8'hd6, 8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hdc, 8'he2};
    logic [0:11] need_en = 12'b001011101111;
    logic [0:11] chain_exp = 12'b111000000101;
    logic [0:11] chain_chk = 12'b111111010111;

    host_cmd_model u_host_cmd_model (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code));
    nfc_direct_command_decoder u_nfc_direct_command_decoder (.sys_clk(sys_clk), .rst_b(rst_b),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .dev_en(dev_en), .tx_en(tx_en),
        .meas_done(meas_done), .rx_cfg4_gain(rx_cfg4_gain), .hist_rd_addr(hist_rd_addr),
        .hist_rd_data(hist_rd_data), .strobe_reg(strobe_reg), .rx_masked_reg(rx_masked_reg),
        .am_state_reg(am_state_reg), .rx_gain_reg(rx_gain_reg), .transparent_reg(transparent_reg),
        .meas_irq_reg(meas_irq_reg), .cmd_ignored_reg(cmd_ignored_reg), .chain_ok_reg(chain_ok_reg));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_vec(input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: vector %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Second measure refused while busy, then completion interrupt
    task automatic scen_measure();
        u_host_cmd_model.issue(8'hd3);
        check_vec(12'h000, strobe_reg);
        check_bit(1'b1, cmd_ignored_reg);
        @(posedge sys_clk);
        #2;
        meas_done = 1'b1;
        @(posedge sys_clk);
        #2;
        meas_done = 1'b0;
        check_bit(1'b1, meas_irq_reg);
        @(posedge sys_clk);
        #2;
        check_bit(1'b0, meas_irq_reg);
    endtask

    // Every code accepted with device and transmitter enabled
    task automatic scen_accept();
        logic am;
        am = 1'b0;
        dev_en = 1'b1;
        tx_en = 1'b1;
        for (int i = 0; i < 12; i++) begin
            u_host_cmd_model.issue(codes[i]);
            check_vec(12'h800 >> i, strobe_reg);
            check_bit(1'b0, cmd_ignored_reg);
            if (chain_chk[i]) check_bit(chain_exp[i], chain_ok_reg);
            if (i == 2) am = ~am;
            check_bit(am, am_state_reg);
            check_bit(i == 0, rx_masked_reg);
            if (i == 3) scen_measure();
        end
        check_vec({8'h00, rx_cfg4_gain}, {8'h00, rx_gain_reg});
        check_bit(1'b1, transparent_reg);
    endtask

    // Mode conditions not met: ignored, no strobe, no state change
    task automatic scen_refuse();
        dev_en = 1'b0;
        for (int i = 0; i < 12; i++) begin
            if (need_en[i]) begin
                u_host_cmd_model.issue(codes[i]);
                check_vec(12'h000, strobe_reg);
                check_bit(1'b1, cmd_ignored_reg);
            end
        end
        u_host_cmd_model.issue(8'hd0);
        check_vec(12'h800, strobe_reg);
        check_bit(1'b1, rx_masked_reg);
        dev_en = 1'b1;
        tx_en = 1'b0;
        u_host_cmd_model.issue(8'hd2);
        check_bit(1'b1, cmd_ignored_reg);
        check_bit(1'b1, am_state_reg);
        u_host_cmd_model.issue(8'h00);
        check_bit(1'b1, cmd_ignored_reg);
    endtask

    // Only accepted codes land in the history, in order
    task automatic scen_history();
        hist_rd_addr = 3'h4;
        @(posedge sys_clk);
        #2;
        check_vec({4'h0, codes[0]}, {4'h0, hist_rd_data});
        hist_rd_addr = 3'h3;
        @(posedge sys_clk);
        #2;
        check_vec({4'h0, codes[11]}, {4'h0, hist_rd_data});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        #(25 * 3000);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        mismatches = 0;
        n_tests = 0;
        rst_b = 1'b0;
        dev_en = 1'b0;
        tx_en = 1'b0;
        meas_done = 1'b0;
        rx_cfg4_gain = 4'ha;
        hist_rd_addr = 3'h0;
        repeat (12) @(posedge sys_clk);
        #2;
        rst_b = 1'b1;
        check_vec(12'h000, strobe_reg);
        check_bit(1'b0, transparent_reg);
        scen_accept();
        scen_refuse();
        scen_history();
        tally_and_finish();
    end
endmodule // test_nfc_direct_command_decoder
`default_nettype wire
